// ### verilog/dmalsd_top.sv
// Channel length, stride, chain pointer and debug block of a DMA engine.
// Assumes an AXI4-Lite master for registers and an AXI memory side whose
// handshakes are reduced to beat and response strobes on plain ports.
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module dmalsd_top #(
  parameter logic [2:0] VERSION_CODE = 3'h1, // Arbitrary value.
  parameter logic [7:0] BUS_ID       = 8'h00,
  parameter int         OUT_W        = 4
) (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        beat_done_i,
  input  wire logic        wr_issue_i,
  input  wire logic        wr_resp_i,
  input  wire logic        rd_resp_valid_i,
  input  wire logic [1:0]  rd_resp_i,
  input  wire logic        rd_last_expected_i,
  input  wire logic        rd_last_i,
  input  wire logic        fifo_error_i,
  output logic [31:0]      src_addr_o,
  output logic [31:0]      dst_addr_o,
  output logic [31:0]      chain_addr_o,
  output logic             busy_o,
  output logic             done_o
);
  // ---------------------------------------------------------------
  // Transfer state machine
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_STRIDE, ST_DONE}
    dmalsd_state_e;

  dmalsd_state_e state;
  dmalsd_state_e next_state;

  logic [31:0]      transfer_length_reg;
  logic [31:0]      row_stride_reg;
  logic [31:0]      chain_block_pointer_reg;
  logic [3:0]       ctrl;
  logic [15:0]      row_bytes;
  logic [OUT_W-1:0] out_count;
  logic [2:0]       err_flags;
  logic             aw_held;
  logic             w_held;
  logic [7:0]       aw_addr;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;

  // ---------------------------------------------------------------
  // Register bus decode
  // ---------------------------------------------------------------
  wire        wr_go    = aw_held && w_held && !s_axi_bvalid_o;
  wire        rd_go    = s_axi_arvalid_i && s_axi_arready_o;
  wire        hit_len  = wr_go && aw_addr == dmalsd_pkg::OFF_LEN;
  wire        hit_str  = wr_go && aw_addr == dmalsd_pkg::OFF_STRIDE;
  wire        hit_chn  = wr_go && aw_addr == dmalsd_pkg::OFF_CHAIN;
  wire        hit_dbg  = wr_go && aw_addr == dmalsd_pkg::OFF_DEBUG;
  wire        hit_ctl  = wr_go && aw_addr == dmalsd_pkg::OFF_CTRL;
  wire        hit_src  = wr_go && aw_addr == dmalsd_pkg::OFF_SRC;
  wire        hit_dst  = wr_go && aw_addr == dmalsd_pkg::OFF_DST;
  wire        wr_known = hit_len || hit_str || hit_chn || hit_dbg ||
                         hit_ctl || hit_src || hit_dst;
  wire [31:0] byte_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                           {8{w_strb[1]}}, {8{w_strb[0]}}};

  // Merge byte lanes of a write into an old register value.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  // ---------------------------------------------------------------
  // Transfer datapath decode
  // ---------------------------------------------------------------
  wire        two_d      = ctrl[dmalsd_pkg::CTRL_TD];
  wire        start_go   = hit_ctl && w_strb[0] &&
                           w_data[dmalsd_pkg::CTRL_START] &&
                           state == ST_IDLE;
  wire [29:0] lin_len    = transfer_length_reg[dmalsd_pkg::ROW_MSB:0];
  wire [13:0] row_cnt    =
    transfer_length_reg[dmalsd_pkg::ROW_MSB:dmalsd_pkg::ROW_LSB];
  wire [15:0] x_len      = transfer_length_reg[dmalsd_pkg::XLEN_MSB:0];
  // Linear count treats both fields as one 30-bit number.
  wire        lin_last   = lin_len <= 30'(dmalsd_pkg::BEAT_BYTES);
  wire        row_last   = x_len <= dmalsd_pkg::BEAT_BYTES16;
  wire [29:0] lin_next   = lin_last ? 30'h0 :
                           lin_len - 30'(dmalsd_pkg::BEAT_BYTES);
  wire [15:0] x_next     = row_last ? 16'h0000 :
                           x_len - dmalsd_pkg::BEAT_BYTES16;
  wire        move_last  = two_d ? row_last : lin_last;
  wire [31:0] d_stride   = {{16{row_stride_reg[31]}},
                            row_stride_reg[31:16]};
  wire [31:0] s_stride   = {{16{row_stride_reg[15]}},
                            row_stride_reg[15:0]};
  wire [31:0] src_step   = ctrl[dmalsd_pkg::CTRL_SRCINC] ?
                           32'(dmalsd_pkg::BEAT_BYTES) : 32'h0000_0000;
  wire [31:0] dst_step   = ctrl[dmalsd_pkg::CTRL_DSTINC] ?
                           32'(dmalsd_pkg::BEAT_BYTES) : 32'h0000_0000;
  wire        beat_ok    = state == ST_MOVE && beat_done_i;
  wire        do_stride  = state == ST_STRIDE;
  wire        more_rows  = row_cnt > 14'h0001;
  wire [8:0]  state_view = 9'(state);

  // Next-state choice for the transfer sequencer.
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:   if (start_go) next_state = ST_MOVE;
      ST_MOVE:   if (beat_ok && move_last)
                   next_state = (two_d && more_rows) ? ST_STRIDE : ST_DONE;
      ST_STRIDE: next_state = ST_MOVE;
      ST_DONE:   next_state = ST_IDLE;
    endcase
  end

  // State register and status outputs.
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      state  <= ST_IDLE;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      busy_o <= next_state != ST_IDLE;
      done_o <= next_state == ST_DONE;
    end
  end

  // Length register: software writes when idle, engine counts down.
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      transfer_length_reg <= dmalsd_pkg::RESET_WORD;
    else if (hit_len && state == ST_IDLE)
      transfer_length_reg <= merge(transfer_length_reg, w_data,
                                   byte_mask) & 32'h3FFF_FFFF;
    else if (beat_ok && two_d)
      transfer_length_reg[15:0] <= x_next;
    else if (beat_ok)
      transfer_length_reg <= {2'h0, lin_next};
    else if (do_stride)
      transfer_length_reg <= {2'h0, row_cnt - 14'h0001,
                              row_bytes};
  end

  // Row byte length is latched at start for reloading each row.
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      row_bytes <= 16'h0000;
    else if (start_go)
      row_bytes <= x_len;
  end

  // Source and destination address registers step and stride.
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      src_addr_o <= dmalsd_pkg::RESET_WORD;
      dst_addr_o <= dmalsd_pkg::RESET_WORD;
    end
    else if (do_stride)
    begin
      src_addr_o <= src_addr_o + s_stride;
      dst_addr_o <= dst_addr_o + d_stride;
    end
    else if (beat_ok)
    begin
      src_addr_o <= src_addr_o + src_step;
      dst_addr_o <= dst_addr_o + dst_step;
    end
    else
    begin
      if (hit_src && state == ST_IDLE)
        src_addr_o <= merge(src_addr_o, w_data, byte_mask);
      if (hit_dst && state == ST_IDLE)
        dst_addr_o <= merge(dst_addr_o, w_data, byte_mask);
    end
  end

  // Stride, chain pointer and control registers from software.
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      row_stride_reg          <= dmalsd_pkg::RESET_WORD;
      chain_block_pointer_reg <= dmalsd_pkg::RESET_WORD;
      ctrl                    <= 4'h0;
    end
    else
    begin
      if (hit_str)
        row_stride_reg <= merge(row_stride_reg, w_data, byte_mask);
      if (hit_chn)
        chain_block_pointer_reg <= merge(chain_block_pointer_reg,
                                         w_data, byte_mask) &
                                   32'hFFFF_FFE0;
      if (hit_ctl && w_strb[0])
        ctrl <= {w_data[3:1], 1'b0};
    end
  end

  // Chain address output drives the next control block fetch.
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      chain_addr_o <= dmalsd_pkg::RESET_WORD;
    else
      chain_addr_o <= chain_block_pointer_reg;
  end

  // Outstanding write counter.
  dmalsd_wcount #(
    .W         (OUT_W)
  ) u_wcount (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .clear_i   (start_go),
    .issue_i   (wr_issue_i),
    .resp_i    (wr_resp_i),
    .count_o   (out_count)
  );

  // Sticky read-side error flags, cleared by writing one.
  wire [2:0] err_set = {rd_resp_valid_i &&
                        rd_resp_i == dmalsd_pkg::AXI_RESP_ERR,
                        fifo_error_i,
                        rd_resp_valid_i && rd_last_expected_i &&
                        !rd_last_i};
  wire [2:0] err_clr = (hit_dbg && w_strb[0]) ?
                       w_data[2:0] : 3'h0;

  dmalsd_sticky #(
    .N         (3)
  ) u_sticky (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .set_i     (err_set),
    .clr_i     (err_clr),
    .flag_o    (err_flags)
  );

  // Debug word; only the flag bits respond to writes.
  wire [31:0] debug_word = {3'h0, dmalsd_pkg::LITE_VALUE,
                            VERSION_CODE,
                            state_view,
                            BUS_ID,
                            4'(out_count),
                            1'b0, err_flags};

  // Read data selection.
  wire [31:0] rd_word =
    (s_axi_araddr_i == dmalsd_pkg::OFF_LEN)    ? transfer_length_reg :
    (s_axi_araddr_i == dmalsd_pkg::OFF_STRIDE) ? row_stride_reg :
    (s_axi_araddr_i == dmalsd_pkg::OFF_CHAIN)  ? chain_block_pointer_reg :
    (s_axi_araddr_i == dmalsd_pkg::OFF_DEBUG)  ? debug_word :
    (s_axi_araddr_i == dmalsd_pkg::OFF_CTRL)   ? {28'h0, ctrl} :
    (s_axi_araddr_i == dmalsd_pkg::OFF_SRC)    ? src_addr_o :
    (s_axi_araddr_i == dmalsd_pkg::OFF_DST)    ? dst_addr_o : 32'h0;
  wire rd_known = s_axi_araddr_i <= dmalsd_pkg::OFF_DST &&
                  s_axi_araddr_i[1:0] == 2'h0;

  // ---------------------------------------------------------------
  // AXI4-Lite write channels
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_addr         <= 8'h00;
      w_data          <= 32'h0;
      w_strb          <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= dmalsd_pkg::AXI_RESP_OK;
    end
    else
    begin
      s_axi_awready_o <= !aw_held && !s_axi_awready_o;
      s_axi_wready_o  <= !w_held && !s_axi_wready_o;
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_go)
      begin
        aw_held        <= 1'b0;
        w_held         <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_known ? dmalsd_pkg::AXI_RESP_OK :
                          dmalsd_pkg::AXI_RESP_ERR;
      end
      else if (s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channels
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0;
      s_axi_rresp_o   <= dmalsd_pkg::AXI_RESP_OK;
    end
    else
    begin
      s_axi_arready_o <= !s_axi_rvalid_o && !rd_go && !s_axi_arready_o;
      if (rd_go)
      begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o  <= rd_word;
        s_axi_rresp_o  <= rd_known ? dmalsd_pkg::AXI_RESP_OK :
                          dmalsd_pkg::AXI_RESP_ERR;
      end
      else if (s_axi_rready_i)
        s_axi_rvalid_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chain_low_zero_a: assert property (@(posedge clk_sys_i)
    disable iff (reset_i) chain_block_pointer_reg[4:0] == 5'h00)
    else $error("chain pointer low bits set");
  stride_adds_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    do_stride |=> src_addr_o == $past(src_addr_o) + $past(s_stride) &&
    dst_addr_o == $past(dst_addr_o) + $past(d_stride))
    else $error("stride not applied");
  length_down_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (beat_ok && !two_d) |=> transfer_length_reg[29:0] == $past(lin_next))
    else $error("linear length not reduced");
  row_reload_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    do_stride |=> transfer_length_reg[15:0] == row_bytes &&
    transfer_length_reg[29:16] == $past(row_cnt) - 14'h0001)
    else $error("row not reloaded");
  lite_zero_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_go && s_axi_araddr_i == dmalsd_pkg::OFF_DEBUG |=>
    s_axi_rdata_o[31:28] == 4'h0 && s_axi_rdata_o[27:25] == VERSION_CODE)
    else $error("debug identity wrong");
  id_view_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_go && s_axi_araddr_i == dmalsd_pkg::OFF_DEBUG |=>
    s_axi_rdata_o[15:8] == BUS_ID &&
    s_axi_rdata_o[24:16] == $past(state_view))
    else $error("debug state or id wrong");
  rerr_set_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_resp_valid_i && rd_resp_i == dmalsd_pkg::AXI_RESP_ERR |=>
    err_flags[2])
    else $error("read error not flagged");
  last_set_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_resp_valid_i && rd_last_expected_i && !rd_last_i |=> err_flags[0])
    else $error("missing last not flagged");
  fifo_set_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    fifo_error_i |=> err_flags[1])
    else $error("fifo error not flagged");
  mode_split_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (beat_ok && two_d && !row_last) |=>
    transfer_length_reg[29:16] == $past(row_cnt))
    else $error("row count moved mid row");
endmodule : dmalsd_top

// ### verilog/dmalsd_pkg.sv
// Constants shared by the channel length, stride and debug block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package dmalsd_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_LEN    = 8'h00;
  localparam logic [7:0] OFF_STRIDE = 8'h04;
  localparam logic [7:0] OFF_CHAIN  = 8'h08;
  localparam logic [7:0] OFF_DEBUG  = 8'h0C;
  localparam logic [7:0] OFF_CTRL   = 8'h10;
  localparam logic [7:0] OFF_SRC    = 8'h14;
  localparam logic [7:0] OFF_DST    = 8'h18;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int ROW_MSB      = 29;
  localparam int ROW_LSB      = 16;
  localparam int XLEN_MSB     = 15;
  localparam int CHAIN_ZERO_W = 5;
  localparam int DBG_LITE     = 28;
  localparam int DBG_VER_LSB  = 25;
  localparam int DBG_ST_LSB   = 16;
  localparam int DBG_ID_LSB   = 8;
  localparam int DBG_OUT_LSB  = 4;
  localparam int DBG_RERR     = 2;
  localparam int DBG_FERR     = 1;
  localparam int DBG_LERR     = 0;
  localparam int CTRL_START   = 0;
  localparam int CTRL_TD      = 1;
  localparam int CTRL_SRCINC  = 2;
  localparam int CTRL_DSTINC  = 3;
  // ---------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------
  localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
  localparam logic        LITE_VALUE   = 1'h0;
  localparam logic [1:0]  AXI_RESP_OK  = 2'h0;
  localparam logic [1:0]  AXI_RESP_ERR = 2'h2;
  localparam logic [2:0]  BEAT_BYTES   = 3'h4;
  localparam logic [15:0] BEAT_BYTES16 = 16'h0004;
endpackage : dmalsd_pkg

// ### verilog/dmalsd_wcount.sv
// Outstanding write counter for one channel.
// Assumes issue and response pulses are single-cycle, in the clk domain.
`timescale 1ns/1ps
module dmalsd_wcount #(
  parameter int W = 4
) (
  input  wire logic         clk_sys_i,
  input  wire logic         reset_i,
  input  wire logic         clear_i,
  input  wire logic         issue_i,
  input  wire logic         resp_i,
  output logic [W-1:0]      count_o
);
  // Up on issue, down on response, cleared at transfer start.
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i || clear_i)
    begin
      count_o <= '0;
    end
    else if (issue_i && !resp_i)
    begin
      count_o <= count_o + W'(1);
    end
    else if (resp_i && !issue_i && count_o != '0)
    begin
      count_o <= count_o - W'(1);
    end
  end

  counter_up_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (!clear_i && issue_i && !resp_i) |=> count_o == $past(count_o) + W'(1))
    else $error("count did not rise");
  counter_clr_a: assert property (@(posedge clk_sys_i)
    clear_i |=> count_o == '0)
    else $error("count not cleared");
endmodule : dmalsd_wcount

// ### verilog/dmalsd_sticky.sv
// Set-priority write-one-to-clear sticky flags.
// Assumes set and clear strobes are synchronous to clk.
`timescale 1ns/1ps
module dmalsd_sticky #(
  parameter int N = 3
) (
  input  wire logic         clk_sys_i,
  input  wire logic         reset_i,
  input  wire logic [N-1:0] set_i,
  input  wire logic [N-1:0] clr_i,
  output logic [N-1:0]      flag_o
);
  genvar g;
  // One flag per bit; a set in the clearing cycle wins.
  generate
    for (g = 0; g < N; g++)
    begin : g_flag
      always_ff @(posedge clk_sys_i)
      begin
        if (reset_i)
          flag_o[g] <= 1'b0;
        else if (set_i[g])
          flag_o[g] <= 1'b1;
        else if (clr_i[g])
          flag_o[g] <= 1'b0;
      end
    end
  endgenerate

  sticky_hold_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (flag_o != '0 && clr_i == '0) |=> (flag_o & $past(flag_o)) ==
    $past(flag_o))
    else $error("flag lost without clear");
endmodule : dmalsd_sticky

// ### dv/dmalsd_far_model.sv
// Far-side memory model: data beats, write issue and response, read events.
// Assumes busy from the block and pacing and faults from the bench.
`timescale 1ns/1ps
module dmalsd_far_model (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        busy_i,
  input  wire logic [15:0] limit_i,
  input  wire logic        resp_en_i,
  input  wire logic [2:0]  inj_i,
  output logic             beat_o,
  output logic             issue_o,
  output logic             resp_o,
  output logic             rvalid_o,
  output logic [1:0]       rresp_o,
  output logic             rlast_exp_o,
  output logic             rlast_o,
  output logic             ferr_o
);
  logic [15:0] cnt;
  logic [7:0]  pend;
  // Beats every other cycle up to the limit; answers writes when allowed.
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      {beat_o, issue_o, resp_o, cnt, pend} <= '0;
    end
    else
    begin
      beat_o  <= busy_i && !beat_o && (cnt < limit_i);
      cnt     <= busy_i ? cnt + 16'(beat_o) : 16'h0000;
      issue_o <= beat_o;
      resp_o  <= resp_en_i && !resp_o && (pend != 8'h00);
      pend    <= pend + 8'(issue_o) - 8'(resp_o);
    end
  end
  // Read-side events exist only while the bench injects them.
  assign rvalid_o    = |inj_i;
  assign rresp_o     = inj_i[2] ? 2'h2 : 2'h0;
  assign rlast_exp_o = inj_i[0];
  assign rlast_o     = !inj_i[0];
  assign ferr_o      = inj_i[1];
endmodule : dmalsd_far_model

// ### dv/testbench.sv
// Self-checking bench for the channel length, stride and debug block.
// Assumes the far model stands in for the memory side.
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] DBG0 = 32'h0200_5A00;
  localparam logic [31:0] SA   = 32'h1000_0000;
  localparam logic [31:0] DA   = 32'h2000_0000;
  logic clk_sys = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, resp_en = 1;
  logic awready, wready, bvalid, arready, rvalid, busy, done;
  logic beat, iss, rsp, rv, rle, rl, fe;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rnd, src, dst, chain;
  logic [1:0]  bresp, rresp, rr;
  logic [15:0] limit = 16'hFFFF;
  logic [2:0]  inj = 0;
  logic [31:0] rq[$];
  logic [1:0]  bq[$];
  int          bad_count = 0, cmp_count = 0;
  // Clock at 25 MHz.
  initial forever #20 clk_sys = ~clk_sys;
  dmalsd_top #(.BUS_ID(8'h5A)) u_dmalsd_top (.clk_sys_i(clk_sys),
    .reset_i(reset), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .beat_done_i(beat),
    .wr_issue_i(iss), .wr_resp_i(rsp), .rd_resp_valid_i(rv),
    .rd_resp_i(rr), .rd_last_expected_i(rle), .rd_last_i(rl),
    .fifo_error_i(fe), .src_addr_o(src), .dst_addr_o(dst),
    .chain_addr_o(chain), .busy_o(busy), .done_o(done));
  dmalsd_far_model u_dmalsd_far_model (.clk_sys_i(clk_sys), .reset_i(reset),
    .busy_i(busy), .limit_i(limit), .resp_en_i(resp_en), .inj_i(inj),
    .beat_o(beat), .issue_o(iss), .resp_o(rsp), .rvalid_o(rv),
    .rresp_o(rr), .rlast_exp_o(rle), .rlast_o(rl), .ferr_o(fe));
  task automatic finish_test;
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic check(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    int n;
    bq.push_back(e);
    @(posedge clk_sys);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    for (n = 0; n < 64 && !bvalid; n++)
    begin
      @(posedge clk_sys);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end
    bready <= 0;
    if (n == 64) begin bad_count++; finish_test(); end
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    int n;
    rq.push_back(e);
    @(posedge clk_sys);
    {araddr, arvalid, rready} <= {a, 2'h3};
    for (n = 0; n < 64 && !rvalid; n++)
    begin
      @(posedge clk_sys);
      if (arready) arvalid <= 0;
    end
    rready <= 0;
    if (n == 64) begin bad_count++; finish_test(); end
  endtask : rd
  task automatic wait_done;
    int n;
    for (n = 0; n < 40000 && !done; n++) @(posedge clk_sys);
    if (n == 40000) begin bad_count++; finish_test(); end
  endtask : wait_done
  // Takes the oldest noted result whenever the bus returns one.
  always @(posedge clk_sys)
  begin
    if (rvalid && rready) check("rdata", rq.pop_front(), rdata);
    if (bvalid && bready) check("bresp", 32'(bq.pop_front()), 32'(bresp));
  end
  // Main sequence.
  initial
  begin
    rnd = $urandom(32'h4c823911);
    repeat (4) @(posedge clk_sys);
    reset <= 0;
    rd(8'h00, 0);
    rd(8'h04, 0);
    rd(8'h0C, DBG0);
    rnd = $urandom;
    wr(8'h08, rnd, 2'h0);
    rd(8'h08, rnd & 32'hFFFF_FFE0);
    check("chain_addr", rnd & 32'hFFFF_FFE0, chain);
    wr(8'h20, rnd, 2'h2);
    @(posedge clk_sys) inj <= 3'h7;
    @(posedge clk_sys) inj <= 3'h0;
    rd(8'h0C, DBG0 | 32'h7);
    wr(8'h0C, 32'h4, 2'h0);
    rd(8'h0C, DBG0 | 32'h3);
    wr(8'h0C, 32'hFFFF_FFF8, 2'h0);
    rd(8'h0C, DBG0 | 32'h3);
    wr(8'h0C, 32'h3, 2'h0);
    rd(8'h0C, DBG0);
    wr(8'h00, 32'h0001_0010, 2'h0);
    wr(8'h14, SA, 2'h0);
    wr(8'h18, DA, 2'h0);
    wr(8'h10, 32'hD, 2'h0);
    wait_done();
    rd(8'h00, 0);
    rd(8'h14, SA + 32'h1_0010);
    resp_en <= 0;
    wr(8'h00, 32'h0003_0008, 2'h0);
    wr(8'h04, 32'hFFF8_0010, 2'h0);
    wr(8'h14, SA, 2'h0);
    wr(8'h18, DA, 2'h0);
    wr(8'h10, 32'hF, 2'h0);
    wait_done();
    rd(8'h14, SA + 32'h38);
    rd(8'h18, DA + 32'h8);
    check("src_addr", SA + 32'h38, src);
    check("dst_addr", DA + 32'h8, dst);
    limit <= 16'h0002;
    wr(8'h00, 32'h0000_0010, 2'h0);
    wr(8'h10, 32'hD, 2'h0);
    repeat (8) @(posedge clk_sys);
    check("busy", 32'h1, 32'(busy));
    rd(8'h00, 32'h8);
    rd(8'h0C, DBG0 | 32'h0001_0020);
    limit <= 16'hFFFF;
    resp_en <= 1;
    wait_done();
    finish_test();
  end
endmodule : testbench
